// file: part_pins_model.sv
/*
  part_pins_model: pin side of the pwm timer: capture sources, a slow
  prescaler clock and loaded pwm pins.
  Assumes a pull-up on every pwm pin.
*/
`timescale 1ns/1ps
module part_pins_model (
  input wire logic aclk, // system clock
  input wire logic [1:0] cap_req, // wanted capture levels
  input wire logic [3:0] pwm_out, // pwm levels from the timer
  input wire logic [3:0] pwm_oe, // pwm enables from the timer
  output logic [1:0] cap_pin, // capture pin levels
  output logic ext_clk, // slow prescaler clock
  output logic [3:0] pin_lvl // resolved pin levels
);
  logic [1:0] div_r = 2'h0; // divider for the slow clock
  initial cap_pin = 2'h0;
  initial ext_clk = 1'b0;
  // sources change just after an edge, as a real driver would
  always @(posedge aclk) cap_pin <= cap_req;
  // quarter rate keeps the clock well under the aclk/2 limit
  always @(posedge aclk) begin
    div_r <= div_r + 2'h1;
    ext_clk <= div_r[1];
  end
  // a released pin floats to the pull-up level
  assign pin_lvl = (pwm_out & pwm_oe) | ~pwm_oe;
endmodule

// file: part_pkg.sv
/*
  part_pkg: register indices, field positions, reset values and response
  codes for the 8-bit PWM auto-reload timer with input capture.
  Assumes a 32-bit AXI4-Lite bus where each register is one aligned word at
  byte address four times its index.
*/
package part_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_DUTY3 = 8'h31;
  localparam logic [7:0] IDX_DUTY2 = 8'h32;
  localparam logic [7:0] IDX_DUTY1 = 8'h33;
  localparam logic [7:0] IDX_DUTY0 = 8'h34;
  localparam logic [7:0] IDX_PWMCTL = 8'h35;
  localparam logic [7:0] IDX_CSR = 8'h36;
  localparam logic [7:0] IDX_CAR = 8'h37;
  localparam logic [7:0] IDX_ARR = 8'h38;
  localparam logic [7:0] IDX_ICCSR = 8'h39;
  localparam logic [7:0] IDX_ICV1 = 8'h3A;
  localparam logic [7:0] IDX_ICV2 = 8'h3B;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h3C;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h3D;
  // timer control/status fields
  localparam int CSR_EXCL = 7;
  localparam int CSR_CC_LO = 4;
  localparam int CSR_TCE = 3;
  localparam int CSR_FCRL = 2;
  localparam int CSR_OIE = 1;
  localparam int CSR_OVF = 0;
  // capture control/status fields
  localparam int ICC_SENS_LO = 4;
  localparam int ICC_IE_LO = 2;
  localparam int ICC_FLAG_LO = 0;
  // interrupt status bits: overflow, capture 1, capture 2
  localparam int IRQ_OVF = 0;
  localparam int IRQ_CAP_LO = 1;
  localparam int IRQ_W = 3;
  // reset values and limits
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] RST_PSC = 7'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: part_timer.sv
/*
  part_timer: 8-bit PWM auto-reload timer with four PWM channels and two
  input capture channels, reached over an AXI4-Lite slave port.
  Assumes all inputs are synchronous to aclk; the external prescaler clock
  arrives as an ordinary sampled input and must be slower than aclk / 2.
*/
// Function
// R01: output enable bit connects channel to pin
// R02: output high while count <= compare, polarity inverts
// R03: polarity change flips output at once
// R04: duty register sets second edge, reload first
// R05: capture control top two bits read zero
// R06: sensitivity bit: zero falling, one rising
// R07: per-channel capture interrupt enable
// R08: capture flag cleared by reading capture value
// R09: capture value read-only, holds captured count
// R10: all registers reset to zero
// R11: register order duty3..0 then control registers
// R12: overflow reloads counter, outputs change level
// R13: capture transfer blocked while flag set
// R14: overflow flag set on wrap, cleared on read
// R15: duty copied to compare at overflow
// R16: sensitivity bits 5:4, enables bits 3:2
`timescale 1ns/1ps
module part_timer
  import part_pkg::*;
(
  input wire logic aclk, // 100 MHz system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [7:0] s_awaddr, // write address
  input wire logic s_awvalid, // write address valid
  output logic s_awready, // write address ready
  input wire logic [31:0] s_wdata, // write data
  input wire logic [3:0] s_wstrb, // write byte strobes
  input wire logic s_wvalid, // write data valid
  output logic s_wready, // write data ready
  output logic [1:0] s_bresp, // write response
  output logic s_bvalid, // write response valid
  input wire logic s_bready, // write response ready
  input wire logic [7:0] s_araddr, // read address
  input wire logic s_arvalid, // read address valid
  output logic s_arready, // read address ready
  output logic [31:0] s_rdata, // read data
  output logic [1:0] s_rresp, // read response
  output logic s_rvalid, // read data valid
  input wire logic s_rready, // read data ready
  input wire logic ext_clk_in, // external prescaler clock input
  input wire logic [1:0] capture_input_pin, // capture inputs, ch2..ch1
  output logic [3:0] pwm_channel_output, // pwm pin levels
  output logic [3:0] pwm_channel_oe, // pwm pin output enables
  output logic irq // level interrupt
);

  // software-visible registers
  logic [7:0] duty_r [4]; // duty_cycle_register per channel
  logic [7:0] pwm_ctl_r; // enables 7:4, polarity 3:0
  logic [7:0] csr_r; // excl, cc, tce, oie (bit 2 and 0 unused here)
  logic ovf_r; // overflow_flag
  logic [7:0] arr_r; // auto_reload_value
  logic [5:2] icc_r; // capture sensitivity and enables
  logic [1:0] cap_flag_r; // capture_flag per channel
  logic [7:0] icv_r [2]; // captured_count per channel
  logic [IRQ_W-1:0] irq_stat_r; // sticky event bits
  logic [IRQ_W-1:0] irq_mask_r; // interrupt mask
  // timer core
  logic [7:0] cnt_r; // auto-reload counter
  logic [6:0] psc_r; // 7-bit prescaler
  logic [7:0] cmp_r [4]; // channel_compare_value
  logic ext_d_r; // delayed external clock for edge detect
  logic [1:0] cap_d_r; // delayed capture inputs
  // bus state
  logic aw_held_r, w_held_r; // address / data captured
  logic [7:0] aw_addr_r; // held write address
  logic [31:0] w_data_r; // held write data
  logic [3:0] w_strb_r; // held strobes

  // decoded strobes
  logic wr_go, rd_go; // write performed / read taken this cycle
  logic [7:0] wr_idx, rd_idx; // register index
  logic [7:0] wbyte; // low byte of write data
  logic wr_lane; // low byte lane enabled
  logic in_tick, cnt_tick, ovf_evt; // prescaler input, counter step, wrap
  logic [6:0] psc_mask; // terminal prescale count
  logic [1:0] cap_evt; // edge seen on a capture input
  logic [1:0] cap_take; // capture actually transferred
  logic [1:0] cap_rd; // capture value read
  logic csr_rd; // control/status read
  logic fcrl_wr; // forced reload request

  assign wr_go = aw_held_r && w_held_r && !s_bvalid;
  assign rd_go = s_arvalid && s_arready;
  assign wr_idx = {2'h0, aw_addr_r[7:2]};
  assign rd_idx = {2'h0, s_araddr[7:2]};
  assign wbyte = w_data_r[7:0];
  assign wr_lane = w_strb_r[0];
  assign csr_rd = rd_go && rd_idx == IDX_CSR;
  assign cap_rd[0] = rd_go && rd_idx == IDX_ICV1;
  assign cap_rd[1] = rd_go && rd_idx == IDX_ICV2;
  assign fcrl_wr = wr_go && wr_lane && wr_idx == IDX_CSR && wbyte[CSR_FCRL];

  // prescaler input: aclk itself or rising edges of the external clock
  assign in_tick = csr_r[CSR_EXCL] ? (ext_clk_in && !ext_d_r) : 1'b1;
  // divide by 2**cc; mask of cc low bits must all be ones
  assign psc_mask = 7'(~(8'hFF << csr_r[6:CSR_CC_LO]));
  assign cnt_tick = csr_r[CSR_TCE] && in_tick && ((psc_r & psc_mask) == psc_mask);
  assign ovf_evt = cnt_tick && cnt_r == CNT_MAX;

  // capture edge detect and transfer gating
  genvar gc;
  generate
    for (gc = 0; gc < 2; gc++) begin : g_cap
      // sensitivity selects rising or falling edge [R06] [R16]
      assign cap_evt[gc] = icc_r[ICC_SENS_LO + gc]
        ? (capture_input_pin[gc] && !cap_d_r[gc])
        : (!capture_input_pin[gc] && cap_d_r[gc]);
      // blocked while the flag is still up, unless read this cycle [R13]
      assign cap_take[gc] = cap_evt[gc] && (!cap_flag_r[gc] || cap_rd[gc]);
    end
  endgenerate

  // input delay stages for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_d_r <= 1'b0;
      cap_d_r <= 2'h0;
    end else begin
      ext_d_r <= ext_clk_in;
      cap_d_r <= capture_input_pin;
    end
  end

  // write address and data channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= RST_BYTE;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
    end else begin
      // each ready only while its own channel holds nothing; one write in flight
      s_awready <= !aw_held_r && !(s_awvalid && s_awready) && !s_bvalid;
      s_wready <= !w_held_r && !(s_wvalid && s_wready) && !s_bvalid;
      if (s_awvalid && s_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_wdata;
        w_strb_r <= s_wstrb;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_bvalid <= 1'b1;
        // unmapped indices answer with a slave error [R11]
        s_bresp <= (wr_idx >= IDX_DUTY3 && wr_idx <= IDX_IRQ_MASK)
          ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= RESP_OKAY;
    end else begin
      s_arready <= !s_rvalid && !rd_go;
      if (rd_go) begin
        s_rvalid <= 1'b1;
        s_rresp <= RESP_OKAY;
        s_rdata <= 32'h0000_0000;
        // address decode in register map order [R11]
        if (rd_idx == IDX_DUTY3) begin
          s_rdata[7:0] <= duty_r[3];
        end else if (rd_idx == IDX_DUTY2) begin
          s_rdata[7:0] <= duty_r[2];
        end else if (rd_idx == IDX_DUTY1) begin
          s_rdata[7:0] <= duty_r[1];
        end else if (rd_idx == IDX_DUTY0) begin
          s_rdata[7:0] <= duty_r[0];
        end else if (rd_idx == IDX_PWMCTL) begin
          s_rdata[7:0] <= pwm_ctl_r;
        end else if (rd_idx == IDX_CSR) begin
          // force-reload bit always reads zero
          s_rdata[7:0] <= {csr_r[7:3], 1'b0, csr_r[CSR_OIE], ovf_r};
        end else if (rd_idx == IDX_CAR) begin
          s_rdata[7:0] <= cnt_r;
        end else if (rd_idx == IDX_ARR) begin
          s_rdata[7:0] <= arr_r;
        end else if (rd_idx == IDX_ICCSR) begin
          s_rdata[7:0] <= {2'h0, icc_r, cap_flag_r}; // [R05]
        end else if (rd_idx == IDX_ICV1) begin
          s_rdata[7:0] <= icv_r[0];
        end else if (rd_idx == IDX_ICV2) begin
          s_rdata[7:0] <= icv_r[1];
        end else if (rd_idx == IDX_IRQ_STAT) begin
          s_rdata[IRQ_W-1:0] <= irq_stat_r;
        end else if (rd_idx == IDX_IRQ_MASK) begin
          s_rdata[IRQ_W-1:0] <= irq_mask_r;
        end else begin
          s_rresp <= RESP_SLVERR; // unmapped: zero data, error
        end
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // configuration registers written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      duty_r <= '{default: RST_BYTE}; // [R10]
      pwm_ctl_r <= RST_BYTE;
      csr_r <= RST_BYTE;
      arr_r <= RST_BYTE;
      icc_r <= 4'h0;
      irq_mask_r <= '0;
    end else if (wr_go && wr_lane) begin
      if (wr_idx == IDX_DUTY3) begin
        duty_r[3] <= wbyte;
      end else if (wr_idx == IDX_DUTY2) begin
        duty_r[2] <= wbyte;
      end else if (wr_idx == IDX_DUTY1) begin
        duty_r[1] <= wbyte;
      end else if (wr_idx == IDX_DUTY0) begin
        duty_r[0] <= wbyte;
      end else if (wr_idx == IDX_PWMCTL) begin
        pwm_ctl_r <= wbyte;
      end else if (wr_idx == IDX_CSR) begin
        // force-reload and overflow bits are not stored here
        csr_r <= {wbyte[7:3], 1'b0, wbyte[CSR_OIE], 1'b0};
      end else if (wr_idx == IDX_ARR) begin
        arr_r <= wbyte;
      end else if (wr_idx == IDX_ICCSR) begin
        icc_r <= wbyte[5:2]; // flags and reserved bits ignored [R16]
      end else if (wr_idx == IDX_IRQ_MASK) begin
        irq_mask_r <= wbyte[IRQ_W-1:0];
      end
      // capture value writes fall through and change nothing [R09]
    end
  end

  // prescaler and counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= RST_BYTE;
      psc_r <= RST_PSC;
    end else if (fcrl_wr) begin
      // forced reload also restarts the prescaler
      cnt_r <= arr_r;
      psc_r <= RST_PSC;
    end else if (wr_go && wr_lane && wr_idx == IDX_CAR) begin
      cnt_r <= wbyte; // on-the-fly counter write
    end else begin
      if (csr_r[CSR_TCE] && in_tick) begin
        psc_r <= cnt_tick ? RST_PSC : psc_r + 7'h01;
      end
      if (ovf_evt) begin
        cnt_r <= arr_r; // wrap loads the reload value [R12] [R04]
      end else if (cnt_tick) begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

  // overflow flag: set on wrap, cleared by reading; set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_r <= 1'b0;
    end else if (ovf_evt) begin
      ovf_r <= 1'b1; // [R14]
    end else if (csr_rd) begin
      ovf_r <= 1'b0; // [R14]
    end
  end

  // per-channel compare and pin logic
  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_pwm
      // compare reloads only at wrap, so a period is never torn [R15]
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cmp_r[gp] <= RST_BYTE;
        end else if (ovf_evt) begin
          cmp_r[gp] <= duty_r[gp]; // [R15] [R04]
        end
      end
      // level from count vs compare, xor polarity with no waiting;
      // the wrap updates all outputs together, one edge after the count moves [R12]
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pwm_channel_output[gp] <= 1'b0;
          pwm_channel_oe[gp] <= 1'b0;
        end else begin
          pwm_channel_output[gp] <= (cnt_r <= cmp_r[gp]) ^ pwm_ctl_r[gp]; // [R02] [R03]
          pwm_channel_oe[gp] <= pwm_ctl_r[4 + gp]; // [R01]
        end
      end
    end
  endgenerate

  // capture flags and values
  genvar gf;
  generate
    for (gf = 0; gf < 2; gf++) begin : g_flag
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cap_flag_r[gf] <= 1'b0;
          icv_r[gf] <= RST_BYTE;
        end else if (cap_take[gf]) begin
          // a capture in the read cycle wins; flag stays up
          cap_flag_r[gf] <= 1'b1; // [R08]
          icv_r[gf] <= cnt_r; // [R09]
        end else if (cap_rd[gf]) begin
          cap_flag_r[gf] <= 1'b0; // [R08]
        end
      end
    end
  endgenerate

  // sticky interrupt status, write one to clear, event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r
        & ~((wr_go && wr_lane && wr_idx == IDX_IRQ_STAT)
            ? wbyte[IRQ_W-1:0] : {IRQ_W{1'b0}}))
        | {cap_take, ovf_evt};
    end
  end

  // interrupt line: masked sticky bits or the native enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r)
        | (csr_r[CSR_OIE] & ovf_r)
        | |(icc_r[3:2] & cap_flag_r); // [R07]
    end
  end

endmodule

// file: part_timer_checker.sv
/*
  part_timer_checker: bus and pin assertions for the pwm timer.
  Assumes it is bound to part_timer and sees only its ports.
*/
`timescale 1ns/1ps
module part_timer_checker (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [7:0] s_awaddr, // write address
  input wire logic s_awvalid, // write address valid
  input wire logic s_awready, // write address ready
  input wire logic s_wvalid, // write data valid
  input wire logic s_wready, // write data ready
  input wire logic [1:0] s_bresp, // write response
  input wire logic s_bvalid, // write response valid
  input wire logic s_bready, // write response ready
  input wire logic [7:0] s_araddr, // read address
  input wire logic s_arvalid, // read address valid
  input wire logic s_arready, // read address ready
  input wire logic [31:0] s_rdata, // read data
  input wire logic [1:0] s_rresp, // read response
  input wire logic s_rvalid, // read data valid
  input wire logic s_rready, // read data ready
  input wire logic [3:0] pwm_channel_output, // pwm levels
  input wire logic [3:0] pwm_channel_oe, // pwm enables
  input wire logic irq // level interrupt
);
  // one clock domain, so clocking and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // outputs are clear at the first edge after release
  property p_rst_out;
    $rose(aresetn) |-> pwm_channel_oe == 4'h0 &&
      pwm_channel_output == 4'h0 && !irq && !s_bvalid && !s_rvalid;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("outputs not clear after reset");
  // enables move only around a write answer
  property p_oe_wr;
    !$stable(pwm_channel_oe) |-> s_bvalid || $past(s_bvalid);
  endproperty
  a_oe_wr: assert property (p_oe_wr)
    else $error("pin enables changed without a write");
  // top two capture control bits always read zero
  property p_rsv;
    s_arvalid && s_arready && s_araddr == 8'hE4 |=> s_rdata[7:6] == 2'h0;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved capture bits not zero");
  // write answer two edges after a joint handshake
  property p_wr_lat;
    s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat)
    else $error("write answer late");
  // an unmapped write is refused with an error code
  property p_wr_err;
    s_awvalid && s_awready && s_wvalid && s_wready && s_awaddr == 8'h00
      |-> ##2 s_bresp == 2'h2;
  endproperty
  a_wr_err: assert property (p_wr_err)
    else $error("unmapped write not refused");
  // read answer one edge after the address is taken
  property p_rd_lat;
    s_arvalid && s_arready |=> s_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer late");
  // an unmapped read returns zero with an error code
  property p_rd_err;
    s_arvalid && s_arready && s_araddr == 8'h00
      |=> s_rresp == 2'h2 && s_rdata == 32'h0;
  endproperty
  a_rd_err: assert property (p_rd_err)
    else $error("unmapped read not refused");
  // answers end once accepted
  property p_bdone;
    s_bvalid && s_bready |=> !s_bvalid;
  endproperty
  a_bdone: assert property (p_bdone)
    else $error("write answer not released");
  property p_rdone;
    s_rvalid && s_rready |=> !s_rvalid;
  endproperty
  a_rdone: assert property (p_rdone)
    else $error("read answer not released");
  // no new write request is taken while a write answer waits
  property p_busy;
    s_bvalid |-> !s_awready && !s_wready;
  endproperty
  a_busy: assert property (p_busy)
    else $error("write taken during pending answer");
endmodule
bind part_timer part_timer_checker part_timer_checker_inst (.aclk,
  .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wvalid, .s_wready,
  .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
  .s_rdata, .s_rresp, .s_rvalid, .s_rready, .pwm_channel_output,
  .pwm_channel_oe, .irq);

// file: tb_part_timer.sv
/*
  tb_part_timer: self-checking bench for the pwm timer over AXI4-Lite.
  Assumes part_pkg, part_timer, the pin model and the bound checker.
*/
`timescale 1ns/1ps
module tb_part_timer;
  import part_pkg::*;
  logic aclk = 1'b0; // 100 MHz clock
  logic aresetn = 1'b0; // sync reset, active low
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00; // addresses
  logic [31:0] s_wdata = 32'h0, s_rdata, v; // bus data
  logic [3:0] s_wstrb = 4'hF; // whole word always written
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0, irq;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, ext_clk_in;
  logic [1:0] s_bresp, s_rresp, r, capture_input_pin, cap_req = 2'h0;
  logic [3:0] pwm_channel_output, pwm_channel_oe, pin_lvl; // pwm side
  logic [7:0] d; // scratch byte
  logic [7:0] rw_idx [6] = '{IDX_DUTY3, IDX_DUTY2, IDX_DUTY1, IDX_DUTY0,
    IDX_CAR, IDX_ARR}; // plain read/write registers
  logic [7:0] cnt_tab [5] = '{8'h10, 8'h10, 8'h80, 8'h81, 8'h90};
  logic pol_tab [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  int errors = 0, tests_run = 0;
  part_timer part_timer_inst (.aclk, .aresetn, .s_awaddr, .s_awvalid,
    .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
    .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .ext_clk_in, .capture_input_pin,
    .pwm_channel_output, .pwm_channel_oe, .irq);
  part_pins_model part_pins_model_inst (.aclk, .cap_req,
    .pwm_out(pwm_channel_output), .pwm_oe(pwm_channel_oe),
    .cap_pin(capture_input_pin), .ext_clk(ext_clk_in), .pin_lvl);
  always #5 aclk = ~aclk; // 10 ns period
  // expected pin level from count, compare and polarity
  function automatic logic pwm_exp(logic [7:0] c, logic [7:0] m, logic p);
    return (c <= m) ^ p;
  endfunction
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // one write; each channel held until its own handshake edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] b);
    @(posedge aclk);
    s_awaddr <= {idx[5:0], 2'b00};
    s_wdata <= {24'h0, b};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    r = 2'bxx;
    // no cycle budget of its own; a hang is left to the watchdog
    forever begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) begin
        r = s_bresp;
        s_bready <= 1'b0;
        break;
      end
    end
  endtask
  // one read; waits for the answer, a hang is left to the watchdog
  task automatic rd(input logic [7:0] idx);
    @(posedge aclk);
    s_araddr <= {idx[5:0], 2'b00};
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    r = 2'bxx;
    v = 32'hx;
    forever begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) begin
        v = s_rdata;
        r = s_rresp;
        s_rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rc(input logic [7:0] idx, input logic [7:0] e);
    rd(idx);
    chk({r, v}, {RESP_OKAY, 24'h0, e});
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog: the whole sequence needs under a thousand cycles
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(68));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(2);
    for (int i = 8'h31; i <= 8'h3D; i++) rc(8'(i), 8'h00);
    rd(8'h00);
    chk({r, v}, {RESP_SLVERR, 32'h0});
    wr(8'h00, 8'h5A);
    chk(r, RESP_SLVERR);
    $display("reset and map test done");
    repeat (3) foreach (rw_idx[i]) begin
      d = 8'($urandom);
      wr(rw_idx[i], d);
      rc(rw_idx[i], d);
    end
    // random enables: released pins must read the pull-up level
    repeat (4) begin
      d = 8'($urandom);
      wr(IDX_PWMCTL, d);
      cyc(2);
      chk({pwm_channel_oe, pin_lvl | d[7:4]}, {d[7:4], 4'hF});
    end
    wr(IDX_ICV1, 8'hA5);
    rc(IDX_ICV1, 8'h00);
    wr(IDX_ICCSR, 8'hFF);
    rc(IDX_ICCSR, 8'h3C);
    $display("register access test done");
    // run one full period so the compare picks up the duty value
    wr(IDX_DUTY0, 8'h80);
    wr(IDX_ARR, 8'h00);
    wr(IDX_CSR, 8'h08);
    cyc(300);
    wr(IDX_CSR, 8'h00);
    rc(IDX_CSR, 8'h01);
    rc(IDX_CSR, 8'h00);
    // forced reload loads the counter; the force bit reads back zero
    wr(IDX_ARR, 8'hFA);
    wr(IDX_CSR, 8'h04);
    rc(IDX_CAR, 8'hFA);
    rc(IDX_CSR, 8'h00);
    // external clock rises every 4 edges, divide by 2: 80 counting edges
    // give 10 steps, FA..FF, wrap to the reload value, then on to FE
    wr(IDX_CSR, 8'h9C);
    cyc(76);
    wr(IDX_CSR, 8'h00);
    rc(IDX_CAR, 8'hFE);
    rc(IDX_CSR, 8'h01);
    for (int k = 0; k < 5; k++) begin
      wr(IDX_CAR, cnt_tab[k]);
      wr(IDX_PWMCTL, {7'h08, pol_tab[k]});
      cyc(2);
      d = {7'h0, pwm_exp(cnt_tab[k], 8'h80, pol_tab[k])};
      chk({pin_lvl[0], pwm_channel_output[0]}, {2{d[0]}});
    end
    // duty change alone must wait for the next overflow
    wr(IDX_DUTY0, 8'hFF);
    cyc(2);
    chk(pwm_channel_output[0], pwm_exp(8'h90, 8'h80, 1'b0));
    $display("pwm output test done");
    rc(IDX_IRQ_STAT, 8'h01);
    chk(irq, 1'b0);
    wr(IDX_IRQ_MASK, 8'h01);
    cyc(2);
    chk(irq, 1'b1);
    wr(IDX_IRQ_STAT, 8'h01);
    cyc(2);
    chk(irq, 1'b0);
    $display("interrupt test done");
    // ch2 on rising edges, ch1 on falling edges with its irq on
    wr(IDX_ICCSR, 8'h24);
    @(posedge aclk) cap_req <= 2'h3;
    cyc(4);
    rc(IDX_ICCSR, 8'h26);
    chk(irq, 1'b0);
    @(posedge aclk) cap_req <= 2'h0;
    cyc(4);
    chk(irq, 1'b1);
    rc(IDX_ICCSR, 8'h27);
    rc(IDX_ICV1, 8'h90);
    rc(IDX_ICCSR, 8'h26);
    cyc(2);
    chk(irq, 1'b0);
    // a second edge while the flag is up must not overwrite the value
    wr(IDX_CAR, 8'h33);
    @(posedge aclk) cap_req <= 2'h2;
    cyc(4);
    rc(IDX_ICV2, 8'h90);
    rc(IDX_ICCSR, 8'h24);
    // both taken captures left their sticky bits, the blocked one none
    rc(IDX_IRQ_STAT, 8'h06);
    $display("capture test done");
    tally_and_finish();
  end
endmodule
